// *** dbe_pkg.sv ***
// package of constants for the data bank and nonvolatile control block
package dbe_pkg;
    // ------------------------------------------------------------------
    // register offsets in data space
    // ------------------------------------------------------------------
    localparam logic [7:0] BANK_SEL_ADDR   = 8'h00_E8;
    localparam logic [7:0] NV_CTRL_ADDR    = 8'h00_EA;
    localparam logic [7:0] BANK_WIN_LAST   = 8'h00_3F;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int RAM_PAGE2_BIT    = 4;
    localparam int NV_PAGE1_BIT     = 1;
    localparam int NV_PAGE0_BIT     = 0;
    localparam int STANDBY_BIT      = 6;
    localparam int PAR_START_BIT    = 3;
    localparam int PAR_MODE_BIT     = 2;
    localparam int BUSY_BIT         = 1;
    localparam int WR_ENABLE_BIT    = 0;
    // ------------------------------------------------------------------
    // reset values and sizes
    // ------------------------------------------------------------------
    localparam logic [7:0] NV_CTRL_RESET  = 8'h00_00;
    localparam logic [7:0] BANK_SEL_INIT  = 8'h00_00;
    localparam int ROW_BYTES        = 8;
    localparam int NV_BYTES         = 128;
    // ------------------------------------------------------------------
    // programming cycle length
    // ------------------------------------------------------------------
    localparam int PROG_TIME_NS     = 1000;
    localparam int CLK_PERIOD_PS    = 5000;
    localparam int PROG_CYCLES      = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                      / CLK_PERIOD_PS;
    localparam logic [15:0] PROG_CYCLES_W = 16'(PROG_CYCLES);
    // programming state machine
    typedef enum logic [1:0] {
        DBE_IDLE,
        DBE_BYTE_PROG,
        DBE_ROW_PROG
    } dbe_state_e;
endpackage

// *** dbe_nv_mem.sv ***
// nonvolatile cell array with registered read data
`timescale 1ns/1ps
module dbe_nv_mem (
    // clock
    input  wire logic       ref_clk,
    input  wire logic       clk_en,
    // write port
    input  wire logic       wr_en,
    input  wire logic [6:0] wr_addr,
    input  wire logic [7:0] wr_data,
    // read port
    input  wire logic [6:0] rd_addr,
    output logic      [7:0] rd_data
);
    logic [7:0] cells [0:127];

    always_ff @(posedge ref_clk) begin
        if (clk_en && wr_en) begin
            cells[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            rd_data <= cells[rd_addr];
        end
    end
endmodule // dbe_nv_mem

// *** dbe_top.sv ***
// data bank selection and nonvolatile memory control
// Notes on behaviour
// - bank bit 4 maps RAM page 2
// - bank bits 1/0 map nonvolatile pages 1/0
// - bank register write-only, no bit ops
// - window 00h-3Fh routes to selected bank
// - bank register untouched by reset
// - no bank or standby makes access void
// - idle nonvolatile reads like ordinary RAM
// - busy flag set during programming, aborts access
// - write cycle needs write-enable bit
// - byte mode and eight-byte row mode
// - control writes ignored while busy
// - STOP disables nonvolatile memory
// - row mode clears latches, writes fill them
// - row is A6..A3, byte A2..A0
// - start programs only written row bytes
// - cycle end clears mode and start
// - start needs write-enable and row mode
// - clearing row mode discards latches
// - control resets to 00h, bits write-only
`timescale 1ns/1ps
module dbe_top #(
    parameter logic [15:0] PROG_LEN = dbe_pkg::PROG_CYCLES_W
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       clk_en,
    // cpu data-space access
    input  wire logic [7:0] cpu_addr,
    input  wire logic [7:0] cpu_wdata,
    input  wire logic       cpu_wr,
    input  wire logic       cpu_rd,
    output logic      [7:0] cpu_rdata,
    output logic            cpu_rdata_valid,
    // power
    input  wire logic       stop_exec,
    // external ram page 2
    output logic            ram2_wr,
    output logic      [5:0] ram2_addr,
    output logic      [7:0] ram2_wdata,
    input  wire logic [7:0] ram2_rdata,
    // status
    output logic            nv_power_on
);
    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic [7:0] bank_q;
    logic       standby_q;
    logic       par_start_q;
    logic       par_mode_q;
    logic       wr_en_q;
    logic       stopped_q;
    dbe_pkg::dbe_state_e state_q;
    logic [15:0] cnt_q;
    logic [7:0] latch_q [0:7];
    logic [7:0] touched_q;
    logic [3:0] row_q;
    logic       row_valid_q;
    logic [6:0] byte_addr_q;
    logic [7:0] byte_data_q;
    logic [2:0] prog_idx_q;

    function automatic logic in_window(input logic [7:0] a);
        in_window = (a <= dbe_pkg::BANK_WIN_LAST);
    endfunction

    logic busy;
    logic nv_sel;
    logic nv_page;
    logic nv_usable;
    logic win_hit;
    logic [6:0] nv_addr;
    logic       ctrl_wr;

    assign busy    = (state_q != dbe_pkg::DBE_IDLE);
    assign win_hit = in_window(cpu_addr);
    assign nv_sel  = bank_q[dbe_pkg::NV_PAGE0_BIT]
                   | bank_q[dbe_pkg::NV_PAGE1_BIT];
    assign nv_page = bank_q[dbe_pkg::NV_PAGE1_BIT];
    assign nv_addr = {nv_page, cpu_addr[5:0]};
    // accesses void without a bank, in standby, stopped or busy
    assign nv_usable = nv_sel && !standby_q && !stopped_q && !busy;
    assign ctrl_wr = cpu_wr && (cpu_addr == dbe_pkg::NV_CTRL_ADDR)
                   && !busy;
    assign nv_power_on = !standby_q && !stopped_q;

    // ------------------------------------------------------------------
    // bank register, no reset
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (clk_en && cpu_wr && cpu_addr == dbe_pkg::BANK_SEL_ADDR) begin
            bank_q <= cpu_wdata;
        end
    end

    // ram page 2 routing
    assign ram2_wr    = clk_en && cpu_wr && win_hit
                      && bank_q[dbe_pkg::RAM_PAGE2_BIT];
    assign ram2_addr  = cpu_addr[5:0];
    assign ram2_wdata = cpu_wdata;

    // ------------------------------------------------------------------
    // stop latch
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            stopped_q <= 1'b0;
        end else if (clk_en) begin
            if (stop_exec) begin
                stopped_q <= 1'b1;
            end else if (ctrl_wr) begin
                stopped_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    logic nv_write;
    logic prog_done;
    assign nv_write  = cpu_wr && win_hit && nv_usable;
    assign prog_done = busy && (cnt_q == 16'h0000);

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            standby_q   <= dbe_pkg::NV_CTRL_RESET[dbe_pkg::STANDBY_BIT];
            par_start_q <= dbe_pkg::NV_CTRL_RESET[dbe_pkg::PAR_START_BIT];
            par_mode_q  <= dbe_pkg::NV_CTRL_RESET[dbe_pkg::PAR_MODE_BIT];
            wr_en_q     <= dbe_pkg::NV_CTRL_RESET[dbe_pkg::WR_ENABLE_BIT];
        end else if (clk_en) begin
            if (prog_done && state_q == dbe_pkg::DBE_ROW_PROG) begin
                par_mode_q  <= 1'b0;
                par_start_q <= 1'b0;
            end else if (ctrl_wr) begin
                standby_q  <= cpu_wdata[dbe_pkg::STANDBY_BIT];
                wr_en_q    <= cpu_wdata[dbe_pkg::WR_ENABLE_BIT];
                par_mode_q <= cpu_wdata[dbe_pkg::PAR_MODE_BIT];
                // start only with enable and row mode already set
                if (cpu_wdata[dbe_pkg::PAR_START_BIT] && wr_en_q
                    && par_mode_q && cpu_wdata[dbe_pkg::PAR_MODE_BIT]
                    && cpu_wdata[dbe_pkg::WR_ENABLE_BIT]) begin
                    par_start_q <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // row latches
    // ------------------------------------------------------------------
    logic enter_row;
    logic leave_row;
    assign enter_row = ctrl_wr && cpu_wdata[dbe_pkg::PAR_MODE_BIT]
                     && !par_mode_q;
    assign leave_row = ctrl_wr && !cpu_wdata[dbe_pkg::PAR_MODE_BIT];

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            touched_q   <= 8'h00_00;
            row_valid_q <= 1'b0;
            row_q       <= 4'h0;
        end else if (clk_en) begin
            if (enter_row || leave_row) begin
                touched_q   <= 8'h00_00;
                row_valid_q <= 1'b0;
            end else if (prog_done && state_q == dbe_pkg::DBE_ROW_PROG) begin
                touched_q   <= 8'h00_00;
                row_valid_q <= 1'b0;
            end else if (nv_write && par_mode_q && wr_en_q) begin
                touched_q[cpu_addr[2:0]] <= 1'b1;
                if (!row_valid_q) begin
                    row_q       <= nv_addr[6:3];
                    row_valid_q <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clk_en && nv_write && par_mode_q && wr_en_q) begin
            latch_q[cpu_addr[2:0]] <= cpu_wdata;
        end
    end

    // ------------------------------------------------------------------
    // programming sequencer
    // ------------------------------------------------------------------
    logic start_row;
    assign start_row = par_start_q && state_q == dbe_pkg::DBE_IDLE;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_q     <= dbe_pkg::DBE_IDLE;
            cnt_q       <= 16'h0000;
            byte_addr_q <= 7'h00;
            byte_data_q <= 8'h00;
            prog_idx_q  <= 3'h0;
        end else if (clk_en) begin
            case (state_q)
                dbe_pkg::DBE_IDLE: begin
                    if (start_row) begin
                        state_q    <= dbe_pkg::DBE_ROW_PROG;
                        cnt_q      <= PROG_LEN;
                        prog_idx_q <= 3'h0;
                    end else if (nv_write && wr_en_q && !par_mode_q) begin
                        state_q     <= dbe_pkg::DBE_BYTE_PROG;
                        cnt_q       <= PROG_LEN;
                        byte_addr_q <= nv_addr;
                        byte_data_q <= cpu_wdata;
                    end
                end
                dbe_pkg::DBE_BYTE_PROG,
                dbe_pkg::DBE_ROW_PROG: begin
                    if (state_q == dbe_pkg::DBE_ROW_PROG) begin
                        prog_idx_q <= prog_idx_q + 3'h1;
                    end
                    if (cnt_q == 16'h0000) begin
                        state_q <= dbe_pkg::DBE_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                default: state_q <= dbe_pkg::DBE_IDLE;
            endcase
        end
    end

    // cells written: byte at cycle end, row bytes one per cycle over the last eight
    logic       mem_wr;
    logic [6:0] mem_waddr;
    logic [7:0] mem_wdata;
    always_comb begin
        mem_wr    = 1'b0;
        mem_waddr = byte_addr_q;
        mem_wdata = byte_data_q;
        if (state_q == dbe_pkg::DBE_BYTE_PROG && cnt_q == 16'h0000) begin
            mem_wr = 1'b1;
        end else if (state_q == dbe_pkg::DBE_ROW_PROG
                     && cnt_q < 16'h0008) begin
            mem_waddr = {row_q, prog_idx_q};
            mem_wdata = latch_q[prog_idx_q];
            mem_wr    = touched_q[prog_idx_q];
        end
    end

    logic [7:0] nv_rdata;
    dbe_nv_mem u_mem (
        .ref_clk (ref_clk),
        .clk_en  (clk_en),
        .wr_en   (mem_wr),
        .wr_addr (mem_waddr),
        .wr_data (mem_wdata),
        .rd_addr (nv_addr),
        .rd_data (nv_rdata)
    );

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    logic       rd_nv_q;
    logic       rd_ram_q;
    logic       rd_ctrl_q;
    logic       rd_any_q;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rd_nv_q   <= 1'b0;
            rd_ram_q  <= 1'b0;
            rd_ctrl_q <= 1'b0;
            rd_any_q  <= 1'b0;
        end else if (clk_en) begin
            rd_any_q  <= cpu_rd;
            rd_nv_q   <= cpu_rd && win_hit && nv_usable;
            rd_ram_q  <= cpu_rd && win_hit
                       && bank_q[dbe_pkg::RAM_PAGE2_BIT];
            rd_ctrl_q <= cpu_rd && cpu_addr == dbe_pkg::NV_CTRL_ADDR;
        end
    end

    logic [7:0] status_byte;
    always_comb begin
        status_byte = 8'h00_00;
        status_byte[dbe_pkg::BUSY_BIT] = busy;
    end

    // bank register reads back as zero
    always_comb begin
        cpu_rdata = 8'h00_00;
        if (rd_nv_q) begin
            cpu_rdata = nv_rdata;
        end else if (rd_ram_q) begin
            cpu_rdata = ram2_rdata;
        end else if (rd_ctrl_q) begin
            cpu_rdata = status_byte;
        end
    end
    assign cpu_rdata_valid = rd_any_q;
endmodule // dbe_top

// *** dbe_chk.sv ***
// assertion checker for the data bank and nonvolatile control block
`timescale 1ns/1ps
module dbe_chk #(
    parameter logic [15:0] PROG_LEN = dbe_pkg::PROG_CYCLES_W
) (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic       clk_en,
    // cpu side
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic       cpu_wr,
    input wire logic       cpu_rd,
    input wire logic [7:0] cpu_rdata,
    input wire logic       cpu_rdata_valid,
    input wire logic       stop_exec,
    // ram page 2 and power
    input wire logic       ram2_wr,
    input wire logic [5:0] ram2_addr,
    input wire logic [7:0] ram2_wdata,
    input wire logic [7:0] ram2_rdata,
    input wire logic       nv_power_on
);
    logic [7:0] bank_q;
    logic       win;
    logic       nv_sel;
    logic       ctl_wr;
    assign win    = cpu_addr <= dbe_pkg::BANK_WIN_LAST;
    assign nv_sel = bank_q == 8'h01 || bank_q == 8'h02;
    assign ctl_wr = cpu_wr && cpu_addr == dbe_pkg::NV_CTRL_ADDR;
    // shadow of the write-only bank register, kept across reset
    always_ff @(posedge ref_clk)
        if (clk_en && cpu_wr && cpu_addr == dbe_pkg::BANK_SEL_ADDR)
            bank_q <= cpu_wdata;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_win_rd; cpu_rd && clk_en && win; endsequence
    sequence s_win_wr; cpu_wr && clk_en && win; endsequence
    a_valid_after_rd: assert property (cpu_rd && clk_en |=> cpu_rdata_valid)
        else $error("read data valid missing");
    a_bank_reads_zero: assert property (cpu_rd && clk_en && cpu_addr ==
        dbe_pkg::BANK_SEL_ADDR |=> cpu_rdata == 8'h00)
        else $error("bank register readable");
    a_ctrl_busy_only: assert property (cpu_rd && clk_en && cpu_addr ==
        dbe_pkg::NV_CTRL_ADDR |=> (cpu_rdata & 8'hFD) == 8'h00)
        else $error("write-only control bits readable");
    a_ram2_wr_route: assert property (s_win_wr ##0 bank_q == 8'h10 |->
        ram2_wr && ram2_addr == cpu_addr[5:0] && ram2_wdata == cpu_wdata)
        else $error("page 2 write not routed");
    a_ram2_no_stray: assert property (ram2_wr |-> cpu_wr && win
        && bank_q == 8'h10)
        else $error("page 2 strobe without page 2 write");
    a_ram2_rd_data: assert property (s_win_rd ##0 bank_q == 8'h10
        |=> cpu_rdata == ram2_rdata)
        else $error("page 2 read data wrong");
    a_none_reads_zero: assert property (s_win_rd ##0 bank_q == 8'h00
        |=> cpu_rdata == 8'h00)
        else $error("unbanked window read not zero");
    a_stop_power_off: assert property (stop_exec && clk_en
        |=> !nv_power_on)
        else $error("stop left nonvolatile power on");
    a_power_stays_off: assert property (!nv_power_on && !ctl_wr
        |=> !nv_power_on)
        else $error("power returned without control write");
    a_off_reads_zero: assert property (s_win_rd ##0 nv_sel && !nv_power_on
        |=> cpu_rdata == 8'h00)
        else $error("read of powered-down memory not zero");
endmodule // dbe_chk

bind dbe_top dbe_chk #(.PROG_LEN(PROG_LEN)) u_chk (
    .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .cpu_rdata_valid(cpu_rdata_valid),
    .stop_exec(stop_exec), .ram2_wr(ram2_wr), .ram2_addr(ram2_addr),
    .ram2_wdata(ram2_wdata), .ram2_rdata(ram2_rdata),
    .nv_power_on(nv_power_on));

// *** dbe_cpu_model.sv ***
// cpu core model issuing data-space reads and writes
`timescale 1ns/1ps
module dbe_cpu_model (
    // clock
    input  wire logic       ref_clk,
    // data-space bus
    output logic      [7:0] cpu_addr,
    output logic      [7:0] cpu_wdata,
    output logic            cpu_wr,
    output logic            cpu_rd,
    input  wire logic [7:0] cpu_rdata
);
    initial begin
        cpu_addr  = 8'h00;
        cpu_wdata = 8'h00;
        cpu_wr    = 1'b0;
        cpu_rd    = 1'b0;
    end
    // whole-byte writes only; released bus shows the inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        cpu_addr  = a;
        cpu_wdata = d;
        cpu_wr    = 1'b1;
        @(negedge ref_clk);
        cpu_wr    = 1'b0;
        cpu_addr  = ~a;
        cpu_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        cpu_addr = a;
        cpu_rd   = 1'b1;
        @(negedge ref_clk);
        cpu_rd   = 1'b0;
        cpu_addr = ~a;
        d        = cpu_rdata;
    endtask
endmodule // dbe_cpu_model

// *** dbe_top_test.sv ***
// self-checking testbench for the data bank and nonvolatile control block
`timescale 1ns/1ps
module dbe_top_test;
    localparam logic [7:0] BK = dbe_pkg::BANK_SEL_ADDR;
    localparam logic [7:0] CT = dbe_pkg::NV_CTRL_ADDR;
    logic       ref_clk, rstn, stop_exec, cpu_wr, cpu_rd, ram2_wr, clk_en;
    logic       cpu_rdata_valid, nv_power_on;
    logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, ram2_rdata, ram2_wdata;
    logic [7:0] rd_v, seed;
    logic [5:0] ram2_addr;
    int         fails = 0;
    int         n_tests = 0;
    int         cyc = 0;
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    dbe_top #(.PROG_LEN(16'h0010)) dut (.ref_clk(ref_clk), .rstn(rstn),
        .clk_en(clk_en), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
        .cpu_rdata_valid(cpu_rdata_valid), .stop_exec(stop_exec),
        .ram2_wr(ram2_wr), .ram2_addr(ram2_addr), .ram2_wdata(ram2_wdata),
        .ram2_rdata(ram2_rdata), .nv_power_on(nv_power_on));
    dbe_cpu_model cpu (.ref_clk(ref_clk), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_rdata(cpu_rdata));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input string w, input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", w, exp, got);
        end
    endtask
    task automatic rchk(input string w, input logic [7:0] a, exp);
        cpu.rd(a, rd_v);
        check(w, rd_v, exp);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            cpu.rd(CT, rd_v);
            n++;
        end while (rd_v[1] !== 1'b0 && n < 100);
        check("busy clears", {7'h00, rd_v[1]}, 8'h00);
    endtask
    // byte program; control write and access during busy must be void
    task automatic prog(input logic [7:0] bank, a, d);
        cpu.wr(BK, bank);
        cpu.wr(a, d);
        rchk("busy set", CT, 8'h02);
        rchk("read while busy", a, 8'h00);
        cpu.wr(CT, 8'h40);
        wait_idle();
        rchk("nv readback", a, d);
        check("power kept", {7'h00, nv_power_on}, 8'h01);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        clk_en = 1'b1;
        stop_exec = 1'b0;
        ram2_rdata = 8'h00;
        seed = 8'h1C;
        repeat (8) @(negedge ref_clk);
        rstn = 1'b1;
        rchk("ctrl reset", CT, 8'h00);
        rchk("bank read", BK, 8'h00);
        $display("test reset done");
        cpu.wr(BK, 8'h10);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            ram2_rdata = ~seed;
            cpu.wr({2'b00, seed[5:0]}, seed);
            rchk("ram2 read", {2'b00, seed[5:0]}, ~seed);
        end
        $display("test ram page done");
        // frozen bank write is dropped, mid-run reset keeps the bank
        clk_en = 1'b0;
        cpu.wr(BK, 8'h00);
        clk_en = 1'b1;
        rstn = 1'b0;
        repeat (2) @(negedge ref_clk);
        rstn = 1'b1;
        ram2_rdata = 8'h3C;
        rchk("bank kept", 8'h07, 8'h3C);
        rchk("ctrl after reset", CT, 8'h00);
        $display("test freeze and reset done");
        cpu.wr(BK, 8'h01);
        cpu.wr(CT, 8'h01);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            prog(i[0] ? 8'h02 : 8'h01, {2'b00, seed[5:0]}, ~seed);
        end
        prog(8'h01, 8'h05, 8'h5A);
        prog(8'h02, 8'h05, 8'hA5);
        cpu.wr(BK, 8'h01);
        rchk("page 0 kept", 8'h05, 8'h5A);
        cpu.wr(CT, 8'h00);
        cpu.wr(8'h05, 8'h33);
        rchk("no cycle", CT, 8'h00);
        rchk("cell kept", 8'h05, 8'h5A);
        $display("test byte mode done");
        cpu.wr(CT, 8'h41);
        rchk("standby read", 8'h05, 8'h00);
        check("standby power", {7'h00, nv_power_on}, 8'h00);
        cpu.wr(CT, 8'h01);
        @(negedge ref_clk);
        stop_exec = 1'b1;
        @(negedge ref_clk);
        stop_exec = 1'b0;
        check("stop power", {7'h00, nv_power_on}, 8'h00);
        rchk("stop read", 8'h05, 8'h00);
        cpu.wr(CT, 8'h01);
        rchk("wake read", 8'h05, 8'h5A);
        cpu.wr(BK, 8'h00);
        rchk("no bank read", 8'h05, 8'h00);
        $display("test power done");
        prog(8'h01, 8'h19, 8'hC3);
        cpu.wr(CT, 8'h05);
        cpu.wr(8'h18, 8'h11);
        cpu.wr(8'h1A, 8'h22);
        cpu.wr(8'h1B, 8'h33);
        cpu.wr(CT, 8'h0D);
        rchk("row busy", CT, 8'h02);
        wait_idle();
        rchk("row byte 0", 8'h18, 8'h11);
        rchk("row byte 1", 8'h19, 8'hC3);
        rchk("row byte 2", 8'h1A, 8'h22);
        rchk("row byte 3", 8'h1B, 8'h33);
        cpu.wr(8'h1C, 8'h44);
        rchk("byte after row", CT, 8'h02);
        wait_idle();
        rchk("byte after row data", 8'h1C, 8'h44);
        cpu.wr(CT, 8'h09);
        rchk("start without mode", CT, 8'h00);
        cpu.wr(CT, 8'h04);
        cpu.wr(CT, 8'h0C);
        rchk("start without enable", CT, 8'h00);
        cpu.wr(CT, 8'h05);
        cpu.wr(8'h18, 8'h99);
        cpu.wr(CT, 8'h01);
        cpu.wr(CT, 8'h09);
        rchk("discard busy", CT, 8'h00);
        rchk("discard data", 8'h18, 8'h11);
        $display("test row mode done");
        report_and_stop();
    end
endmodule // dbe_top_test
